/* File: nv_byte_store_map.svh */
`ifndef NV_BYTE_STORE_MAP_SVH
`define NV_BYTE_STORE_MAP_SVH

// Register indexes on the register port
`define NV_OFS_BYTE_DATA   3'h0
`define NV_OFS_INDEX_LOW   3'h1
`define NV_OFS_INDEX_HIGH  3'h2
`define NV_OFS_CONTROL     3'h3
`define NV_OFS_UNLOCK      3'h4
`define NV_OFS_PRIO2       3'h5
`define NV_OFS_FLAG2       3'h6
`define NV_OFS_MASK2       3'h7

// nv_control field positions
`define NV_BIT_FLASH_SEL   7
`define NV_BIT_CONFIG_SEL  6
`define NV_BIT_ROW_ERASE   4
`define NV_BIT_ABORT       3
`define NV_BIT_PERMIT      2
`define NV_BIT_GO          1
`define NV_BIT_READ        0
// Done flag, mask and priority position in the peripheral registers
`define NV_BIT_DONE        4

// Unlock keys and erased value
`define NV_KEY_FIRST       8'h55
`define NV_KEY_SECOND      8'hAA
`define NV_ERASED_BYTE     8'hFF

// Reset values
`define NV_RST_BYTE        8'h00
`define NV_RST_ABORT       1'b1

// Self-timed write length
`define NV_WRITE_TIME_NS   4000000
`define NV_MCLK_PERIOD_NS  50

`endif

/* File: nv_byte_store_pkg.sv */
`default_nettype none
package nv_byte_store_pkg;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Single array port request
    typedef struct packed {
        logic       en;
        logic       we;
        logic [9:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    // Operation handed to the program flash or configuration datapath
    typedef struct packed {
        logic active;
        logic row_erase;
        logic config_space;
    } flash_op_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_FIRST = 2'b01,
        SEQ_ARMED = 2'b10
    } unlock_state_t;

    typedef enum logic [1:0] {
        CYC_IDLE  = 2'b00,
        CYC_ERASE = 2'b01,
        CYC_PROG  = 2'b10
    } cycle_state_t;

endpackage
`default_nettype wire

/* File: nv_byte_array.sv */
`default_nettype none
module nv_byte_array
    import nv_byte_store_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic       mclk,
    input  wire mem_req_t   req,
    output var  logic [7:0] rdata
);
    // Port struct fixes the address at ten bits
    if (AW != 10 || DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
        $error("nv_byte_array: unsupported size");
    end

    logic [7:0] cells [DEPTH];

    // One port: a write or a registered read per cycle; no reset on the cells
    always_ff @(posedge mclk) begin
        if (req.en && req.we) begin
            cells[req.addr] <= req.wdata;
        end
        if (req.en && !req.we) begin
            rdata <= cells[req.addr];
        end
    end

endmodule // nv_byte_array
`default_nettype wire

/* File: nv_byte_store_control.sv */
// The register offsets and the strobed register port were left to the implementer.
`include "nv_byte_store_map.svh"
`default_nettype none
module nv_byte_store_control
    import nv_byte_store_pkg::*;
#(
    parameter int WRITE_CYCLES = (`NV_WRITE_TIME_NS + `NV_MCLK_PERIOD_NS - 1) / `NV_MCLK_PERIOD_NS,
    parameter int DEPTH        = 1024
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire reg_req_t   bus_req,
    output var  logic [7:0] bus_rdata,
    output var  logic       write_busy,
    output var  flash_op_t  flash_op,
    output var  logic       flash_op_done
);
    localparam int ERASE_CYCLES = WRITE_CYCLES / 2;
    localparam int PROG_CYCLES  = WRITE_CYCLES - ERASE_CYCLES;
    localparam int TW           = $clog2(WRITE_CYCLES + 1);

    if (WRITE_CYCLES < 4) begin : g_bad_timer
        $error("nv_byte_store_control: WRITE_CYCLES below 4");
    end

    localparam logic [TW-1:0] ERASE_LOAD = TW'(ERASE_CYCLES - 1);
    localparam logic [TW-1:0] PROG_LOAD  = TW'(PROG_CYCLES - 1);

    function automatic logic hit(input reg_req_t r, input logic [2:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // Register state
    logic [7:0]    nv_byte_data;
    logic [7:0]    nv_index_low;
    logic [1:0]    nv_index_high;
    logic          flash_space_sel;
    logic          config_space_sel;
    logic          row_erase_arm;
    logic          abort_flag;
    logic          program_permit;
    logic          program_cycle_go;
    logic          read_start;
    logic          nv_done_flag;
    logic          nv_done_mask;
    logic          nv_done_prio;
    unlock_state_t seq;
    unlock_state_t next_seq;
    cycle_state_t  cyc;
    cycle_state_t  next_cyc;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic [7:0]    mem_rdata;
    mem_req_t      mem_req;

    // Write decode; busy freezes the data, index and control registers, not unlock, flag, mask or priority
    wire       busy        = (cyc != CYC_IDLE);
    wire       wr_data     = hit(bus_req, `NV_OFS_BYTE_DATA) && !busy;
    wire       wr_low      = hit(bus_req, `NV_OFS_INDEX_LOW) && !busy;
    wire       wr_high     = hit(bus_req, `NV_OFS_INDEX_HIGH) && !busy;
    wire       wr_ctrl     = hit(bus_req, `NV_OFS_CONTROL) && !busy;
    wire       wr_unlock   = hit(bus_req, `NV_OFS_UNLOCK);
    wire       wr_flag     = hit(bus_req, `NV_OFS_FLAG2);
    wire [7:0] wd          = bus_req.wdata;
    wire [9:0] byte_addr   = {nv_index_high, nv_index_low};
    wire       data_space  = !flash_space_sel && !config_space_sel;

    // Start needs a finished unlock and a permit set in an earlier write
    wire go_req      = wr_ctrl && wd[`NV_BIT_GO];
    wire start_ok    = go_req && (seq == SEQ_ARMED) && program_permit;
    wire bad_go      = go_req && !start_ok;
    wire permit_rise = wr_ctrl && wd[`NV_BIT_PERMIT] && !program_permit;
    wire read_set    = wr_ctrl && wd[`NV_BIT_READ]
                       && !wd[`NV_BIT_FLASH_SEL] && !wd[`NV_BIT_CONFIG_SEL];
    wire phase_end   = busy && (timer == '0);
    wire cycle_end   = (cyc == CYC_PROG) && phase_end;

    // Unlock sequence: any write elsewhere breaks it
    always_comb begin
        next_seq = seq;
        if (wr_unlock) begin
            if (seq == SEQ_FIRST && wd == `NV_KEY_SECOND) begin
                next_seq = SEQ_ARMED;
            end else if (wd == `NV_KEY_FIRST) begin
                next_seq = SEQ_FIRST;
            end else begin
                next_seq = SEQ_IDLE;
            end
        end else if (bus_req.wr) begin
            next_seq = SEQ_IDLE;
        end
    end

    // Self-timed cycle: erase phase then program phase
    always_comb begin
        next_cyc   = cyc;
        next_timer = timer;
        unique case (cyc)
            CYC_IDLE: begin
                if (start_ok) begin
                    next_cyc   = CYC_ERASE;
                    next_timer = ERASE_LOAD;
                end
            end
            CYC_ERASE: begin
                if (phase_end) begin
                    next_cyc   = CYC_PROG;
                    next_timer = PROG_LOAD;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            CYC_PROG: begin
                if (phase_end) begin
                    next_cyc = CYC_IDLE;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            default: begin
                next_cyc = CYC_IDLE;
            end
        endcase
    end

    // Array port: erase at end of erase phase, program at end, reads otherwise
    wire arr_write = phase_end && data_space && !row_erase_arm;
    assign mem_req.en    = arr_write || read_set;
    assign mem_req.we    = arr_write;
    assign mem_req.addr  = byte_addr;
    assign mem_req.wdata = (cyc == CYC_ERASE) ? `NV_ERASED_BYTE : nv_byte_data;

    nv_byte_array #(
        .DEPTH (DEPTH),
        .AW    (10)
    ) u_array (
        .mclk  (mclk),
        .req   (mem_req),
        .rdata (mem_rdata)
    );

    // State machines
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seq   <= SEQ_IDLE;
            cyc   <= CYC_IDLE;
            timer <= '0;
        end else begin
            seq   <= next_seq;
            cyc   <= next_cyc;
            timer <= next_timer;
        end
    end

    // Index and data registers; a software write beats a load from a read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nv_byte_data  <= `NV_RST_BYTE;
            nv_index_low  <= `NV_RST_BYTE;
            nv_index_high <= 2'h0;
        end else begin
            if (wr_data) begin
                nv_byte_data <= wd;
            end else if (read_start) begin
                nv_byte_data <= mem_rdata;
            end
            if (wr_low) begin
                nv_index_low <= wd;
            end
            if (wr_high) begin
                nv_index_high <= wd[1:0];
            end
        end
    end

    // Control fields; abort_flag starts set because a reset may cut a write short
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flash_space_sel  <= 1'b0;
            config_space_sel <= 1'b0;
            row_erase_arm    <= 1'b0;
            abort_flag       <= `NV_RST_ABORT;
            program_permit   <= 1'b0;
            program_cycle_go <= 1'b0;
            read_start       <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                flash_space_sel  <= wd[`NV_BIT_FLASH_SEL];
                config_space_sel <= wd[`NV_BIT_CONFIG_SEL];
                program_permit   <= wd[`NV_BIT_PERMIT];
            end
            if (wr_ctrl) begin
                row_erase_arm <= wd[`NV_BIT_ROW_ERASE];
            end else if (cycle_end) begin
                row_erase_arm <= 1'b0;
            end
            // Hardware set wins over a software write or the completion clear
            if (permit_rise || bad_go) begin
                abort_flag <= 1'b1;
            end else if (cycle_end) begin
                abort_flag <= 1'b0;
            end else if (wr_ctrl) begin
                abort_flag <= wd[`NV_BIT_ABORT];
            end
            if (start_ok) begin
                program_cycle_go <= 1'b1;
            end else if (cycle_end) begin
                program_cycle_go <= 1'b0;
            end
            read_start <= read_set;
        end
    end

    // Peripheral flag, mask and priority bits; completion beats a clearing write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nv_done_flag <= 1'b0;
            nv_done_mask <= 1'b0;
            nv_done_prio <= 1'b0;
        end else begin
            if (cycle_end) begin
                nv_done_flag <= 1'b1;
            end else if (wr_flag) begin
                nv_done_flag <= wd[`NV_BIT_DONE];
            end
            if (hit(bus_req, `NV_OFS_MASK2)) begin
                nv_done_mask <= wd[`NV_BIT_DONE];
            end
            if (hit(bus_req, `NV_OFS_PRIO2)) begin
                nv_done_prio <= wd[`NV_BIT_DONE];
            end
        end
    end

    // Read mux; unimplemented bits and the unlock port read zero
    wire [7:0] ctrl_view = {flash_space_sel, config_space_sel, 1'b0, row_erase_arm,
                            abort_flag, program_permit, program_cycle_go, read_start};
    wire [7:0] done_bit  = 8'h10;
    logic [7:0] read_mux;
    always_comb begin
        unique case (bus_req.addr)
            `NV_OFS_BYTE_DATA:  read_mux = nv_byte_data;
            `NV_OFS_INDEX_LOW:  read_mux = nv_index_low;
            `NV_OFS_INDEX_HIGH: read_mux = {6'h00, nv_index_high};
            `NV_OFS_CONTROL:    read_mux = ctrl_view;
            `NV_OFS_UNLOCK:     read_mux = 8'h00;
            `NV_OFS_PRIO2:      read_mux = nv_done_prio ? done_bit : 8'h00;
            `NV_OFS_FLAG2:      read_mux = nv_done_flag ? done_bit : 8'h00;
            `NV_OFS_MASK2:      read_mux = nv_done_mask ? done_bit : 8'h00;
        endcase
    end

    // Output registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata     <= 8'h00;
            flash_op      <= '0;
            flash_op_done <= 1'b0;
        end else begin
            bus_rdata            <= bus_req.rd ? read_mux : 8'h00;
            flash_op.active      <= (next_cyc != CYC_IDLE) && !data_space;
            flash_op.row_erase   <= (next_cyc != CYC_IDLE) && row_erase_arm;
            flash_op.config_space <= (next_cyc != CYC_IDLE) && config_space_sel;
            flash_op_done        <= cycle_end && (!data_space || row_erase_arm);
        end
    end

    // CPU stall indication follows the cycle state
    assign write_busy = busy;

    // Helper: length of the current self-timed cycle
    logic [TW:0] busy_len;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy ? busy_len + 1'b1 : '0;
        end
    end

    a_start_unlocked: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(busy) |-> $past(seq) == SEQ_ARMED && $past(program_permit))
        else $error("write began without unlock or permit");
    a_permit_needed: assert property (@(posedge mclk) disable iff (!reset_n)
        !program_permit && !busy |=> !busy)
        else $error("write began with permit low");
    a_go_tracks_busy: assert property (@(posedge mclk) disable iff (!reset_n)
        program_cycle_go == busy)
        else $error("go bit does not follow the cycle");
    a_timer_length: assert property (@(posedge mclk) disable iff (!reset_n)
        cycle_end |-> busy_len == (TW+1)'(WRITE_CYCLES - 1))
        else $error("write cycle length wrong");
    a_erase_then_prog: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(cyc == CYC_PROG) |-> $past(cyc) == CYC_ERASE
            && ($past(mem_req.we && mem_req.wdata == `NV_ERASED_BYTE)
                || !$past(data_space) || $past(row_erase_arm)))
        else $error("program phase without erase");
    a_done_after_end: assert property (@(posedge mclk) disable iff (!reset_n)
        cycle_end |=> nv_done_flag && !abort_flag && !program_cycle_go)
        else $error("completion did not update flags");
    a_regs_frozen: assert property (@(posedge mclk) disable iff (!reset_n)
        busy ##1 busy |-> $stable(nv_byte_data) && $stable(byte_addr)
                          && $stable(flash_space_sel) && $stable(config_space_sel))
        else $error("registers changed during a write");
    a_read_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
        read_start |-> !flash_space_sel && !config_space_sel
            ##1 (!read_start || $past(wr_ctrl && wd[`NV_BIT_READ])))
        else $error("read bit misbehaved");
    a_read_lands: assert property (@(posedge mclk) disable iff (!reset_n)
        read_start && !wr_data |=> nv_byte_data == $past(mem_rdata))
        else $error("read data not loaded");
    a_unlock_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `NV_OFS_UNLOCK |=> bus_rdata == 8'h00)
        else $error("unlock port read nonzero");
    a_bit5_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `NV_OFS_CONTROL |=> bus_rdata[5] == 1'b0)
        else $error("bit 5 read nonzero");
    a_row_cleared: assert property (@(posedge mclk) disable iff (!reset_n)
        cycle_end && row_erase_arm |=> !row_erase_arm)
        else $error("row erase bit not cleared");

    // Flag ownership and decode guards; hardware sets must never be lost
    a_abort_set_wins: assert property (@(posedge mclk) disable iff (!reset_n)
        permit_rise || bad_go |=> abort_flag)
        else $error("abort flag not raised");
    a_done_held: assert property (@(posedge mclk) disable iff (!reset_n)
        nv_done_flag && !wr_flag |=> nv_done_flag)
        else $error("done flag cleared without software");
    a_sel_kept: assert property (@(posedge mclk) disable iff (!reset_n)
        !wr_ctrl |=> $stable(flash_space_sel) && $stable(config_space_sel))
        else $error("space selects changed by hardware");
    a_flash_no_array: assert property (@(posedge mclk) disable iff (!reset_n)
        !data_space |-> !mem_req.we)
        else $error("array written outside data space");
    a_seq_broken: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_req.wr && bus_req.addr != `NV_OFS_UNLOCK |=> seq == SEQ_IDLE)
        else $error("unlock sequence survived a stray write");
    a_read_refused: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_req.wr && bus_req.addr == `NV_OFS_CONTROL && (bus_req.wdata[7] || bus_req.wdata[6]) |=> !read_start)
        else $error("read started with a space select set");

    c_byte_write: cover property (@(posedge mclk) disable iff (!reset_n)
        cycle_end && data_space && !row_erase_arm);
    c_byte_read: cover property (@(posedge mclk) disable iff (!reset_n) read_start);
    c_row_erase: cover property (@(posedge mclk) disable iff (!reset_n) cycle_end && row_erase_arm);
    c_bad_go: cover property (@(posedge mclk) disable iff (!reset_n) bad_go);
    c_flash_cycle: cover property (@(posedge mclk) disable iff (!reset_n) cycle_end && !data_space);

endmodule // nv_byte_store_control
`default_nettype wire

/* File: nv_byte_store_control_tb.sv */
`include "nv_byte_store_map.svh"
`default_nettype none
module nv_byte_store_control_tb
    import nv_byte_store_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int WCYC = 8;

    logic       mclk;
    logic       reset_n;
    reg_req_t   bus_req;
    logic [7:0] bus_rdata;
    logic       write_busy;
    flash_op_t  flash_op;
    logic       flash_op_done;
    int         n_fail    = 0;
    int         tests_run = 0;
    int         busy_len;
    int         done_cnt;
    flash_op_t  op_seen;
    logic       rd_pend   = 1'b0;
    logic [31:0] seed     = 32'h0000003B;
    logic [7:0] exp_q[$];
    string      name_q[$];
    logic [7:0] d2;
    logic [7:0] d3;
    logic [7:0] d4;
    logic [7:0] modes[3] = '{8'h80, 8'hC0, 8'h90};
    logic [7:0] sels[2]  = '{8'h81, 8'h41};

    // Short timer so a full write costs a handful of cycles
    nv_byte_store_control #(.WRITE_CYCLES(WCYC)) i_nv_byte_store_control (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .bus_req       (bus_req),
        .bus_rdata     (bus_rdata),
        .write_busy    (write_busy),
        .flash_op      (flash_op),
        .flash_op_done (flash_op_done)
    );

    // Free-running processor clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One request per edge; back-to-back calls never touch a signal twice in a step
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        name_q.push_back(n);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle();
        bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask

    // Read data only stand in the cycle after the strobe, so they are taken mid-cycle
    always @(posedge mclk) rd_pend <= bus_req.rd;
    always @(negedge mclk) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0) check8(name_q.pop_front(), exp_q.pop_front(), bus_rdata);
        if (write_busy === 1'b1) busy_len++;
        if (write_busy === 1'b1) op_seen = flash_op;
        if (flash_op_done === 1'b1) done_cnt++;
    end

    // brk 0 proper, 1 stray write inside the unlock keys, 2 go without permit
    task automatic do_write(input logic [7:0] m, input logic [9:0] a, input logic [7:0] d, input int brk);
        logic      ok;
        flash_op_t eo;
        ok = (brk == 0);
        eo = '{active: ok & (m[7] | m[6]), row_erase: ok & m[4], config_space: ok & m[6]};
        busy_len = 0;
        done_cnt = 0;
        op_seen = '0;
        wr(`NV_OFS_INDEX_HIGH, {6'b101101, a[9:8]});
        wr(`NV_OFS_INDEX_LOW, a[7:0]);
        wr(`NV_OFS_BYTE_DATA, d);
        wr(`NV_OFS_CONTROL, (brk == 2) ? m : (m | 8'h04));
        wr(`NV_OFS_UNLOCK, `NV_KEY_FIRST);
        if (brk == 1) wr(`NV_OFS_PRIO2, 8'h10);
        wr(`NV_OFS_UNLOCK, `NV_KEY_SECOND);
        wr(`NV_OFS_CONTROL, m | ((brk == 2) ? 8'h02 : 8'h06));
        // These land while busy and must be dropped on a launched write
        wr(`NV_OFS_BYTE_DATA, ~d);
        wr(`NV_OFS_INDEX_LOW, ~a[7:0]);
        idle();
        repeat (WCYC + 6) @(negedge mclk);
        check8("busy cycles", ok ? WCYC[7:0] : 8'h00, busy_len[7:0]);
        check8("done pulses", (ok & (m[7] | m[6] | m[4])) ? 8'h01 : 8'h00, done_cnt[7:0]);
        check8("flash op", {5'h00, eo}, {5'h00, op_seen});
        rd(`NV_OFS_BYTE_DATA, ok ? d : ~d, "byte data");
        rd(`NV_OFS_INDEX_LOW, ok ? a[7:0] : ~a[7:0], "index low");
        rd(`NV_OFS_INDEX_HIGH, {6'h00, a[9:8]}, "index high");
        rd(`NV_OFS_CONTROL, ok ? ((m & 8'hEF) | 8'h04) : (m | ((brk == 2) ? 8'h08 : 8'h0C)), "control");
        rd(`NV_OFS_FLAG2, ok ? 8'h10 : 8'h00, "done flag");
        wr(`NV_OFS_FLAG2, 8'h00);
        rd(`NV_OFS_FLAG2, 8'h00, "done flag cleared");
        idle();
    endtask

    task automatic do_read(input logic [9:0] a, input logic [7:0] e);
        wr(`NV_OFS_INDEX_HIGH, {6'h00, a[9:8]});
        wr(`NV_OFS_INDEX_LOW, a[7:0]);
        wr(`NV_OFS_CONTROL, 8'h01);
        idle();
        rd(`NV_OFS_BYTE_DATA, e, "read byte");
        rd(`NV_OFS_BYTE_DATA, e, "read byte held");
        rd(`NV_OFS_CONTROL, 8'h00, "read start cleared");
        idle();
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        bus_req = '0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`NV_OFS_CONTROL, 8'h08, "control at reset");
        rd(`NV_OFS_BYTE_DATA, 8'h00, "data at reset");
        wr(`NV_OFS_UNLOCK, 8'hFF);
        rd(`NV_OFS_UNLOCK, 8'h00, "unlock port");
        wr(`NV_OFS_CONTROL, 8'h20);
        rd(`NV_OFS_CONTROL, 8'h00, "unused bit");
        wr(`NV_OFS_CONTROL, 8'h04);
        rd(`NV_OFS_CONTROL, 8'h0C, "permit sets abort");
        wr(`NV_OFS_MASK2, 8'hFF);
        rd(`NV_OFS_MASK2, 8'h10, "done mask");
        idle();
        d2 = rnd();
        d3 = rnd();
        d4 = rnd();
        do_write(8'h00, 10'h123, rnd(), 0);
        do_write(8'h00, 10'h023, d2, 0);
        do_write(8'h00, 10'h123, d3, 0);
        do_read(10'h123, d3);
        do_read(10'h023, d2);
        do_write(8'h00, 10'h023, d4, 1);
        rd(`NV_OFS_PRIO2, 8'h10, "done priority");
        do_write(8'h00, 10'h023, d4, 2);
        do_read(10'h023, d2);
        foreach (sels[i]) begin
            wr(`NV_OFS_CONTROL, sels[i]);
            idle();
            rd(`NV_OFS_BYTE_DATA, d2, "refused read data");
            rd(`NV_OFS_CONTROL, sels[i] & 8'hFE, "refused read start");
        end
        do_write(8'h00, 10'h3FF, d4, 0);
        foreach (modes[i]) do_write(modes[i], 10'h3FF, rnd(), 0);
        do_read(10'h3FF, d4);
        // Reset in the middle of a self-timed write
        wr(`NV_OFS_CONTROL, 8'h04);
        wr(`NV_OFS_UNLOCK, `NV_KEY_FIRST);
        wr(`NV_OFS_UNLOCK, `NV_KEY_SECOND);
        wr(`NV_OFS_CONTROL, 8'h06);
        idle();
        repeat (3) @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        check8("busy after reset", 8'h00, {7'h00, write_busy});
        rd(`NV_OFS_CONTROL, 8'h08, "abort after reset");
        do_read(10'h3FF, d4);
        idle();
        repeat (4) @(posedge mclk);
        final_report();
    end

endmodule // nv_byte_store_control_tb
`default_nettype wire
